// *** strap_sampler_regs.svh ***
// Register offsets, field positions, reset values and timing counts of the strap sampler.
`ifndef STRAP_SAMPLER_REGS_SVH
`define STRAP_SAMPLER_REGS_SVH

`define CLK_PERIOD_NS 50
`define HANDBACK_NS 200
`define HANDBACK_CYC ((`HANDBACK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define OFS_STATUS 12'h000
`define OFS_SYSTEM_CONFIG 12'h004
`define OFS_SDRAM_CONFIG 12'h008

`define PIN_BOOT_ROM_SELECT 0
`define PIN_MASTER_INDICATOR 1
`define PIN_TIMER_ZERO_EXPIRY 2
`define PIN_ARBITRATION_HOLD 3
`define PIN_LINK_ONE_DONE 4
`define PIN_LINK_TWO_DONE 5
`define PIN_LINK_THREE_DONE 6
`define STRAP_PINS 7

`define RST_PULL_UP_MASK 7'h70
`define RST_PULL_DN_MASK 7'h0f
`define RUN_PULL_UP_MASK 7'h09
`define RUN_DRIVEN_MASK 7'h76
`define ID_ZERO_ONLY_MASK 7'h09

`define STS_BOOT_BIT 0
`define STS_IRQ_BIT 1
`define STS_LINK_BIT 2
`define STS_UNLOCK_BIT 3
`define STS_TEST_LSB 4
`define STS_VALID_BIT 8
`define STS_RUN_BIT 9
`define STS_SYS_WRITTEN_BIT 10
`define STS_SDR_WRITTEN_BIT 11
`define STS_ID_ZERO_BIT 12

`define SYSTEM_CONFIG_RESET 32'h0000_0000
`define SDRAM_CONFIG_RESET 32'h0000_0000
`define PROC_ID_W 3

`endif

// *** strap_sampler_pkg.sv ***
// Types shared by the strap sampler modules.
`default_nettype none
package strap_sampler_pkg;
    typedef enum logic [1:0] {
        ST_IN_RESET = 2'b00,
        ST_HANDBACK = 2'b01,
        ST_RUN = 2'b11
    } strap_state_t;
    typedef logic [6:0] pin_vec_t;
endpackage
`default_nettype wire

// *** strap_sync.sv ***
// Two-flop synchroniser for pin inputs.
`default_nettype none
module strap_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;

    generate
        if (W < 1)
        begin : g_bad_width
            $error("W must be at least 1");
        end
    endgenerate

    // Only the second flop reads the first one.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            meta_r <= '0;
            q_r <= '0;
        end
        else
        begin
            meta_r <= d;
            q_r <= meta_r;
        end
    end

    assign q = q_r;
endmodule
`default_nettype wire

// *** reset_strap_sampler.sv ***
// Strap capture at reset release, pad pull control and write-once configuration registers.
//
// What this block does
// - Latch every strap pin at reset release.
// - Undriven strap reads internal pull default.
// - Return pins to normal function shortly after.
// - Boot strap: 0 ROM boot, 1 wait.
// - Interrupt strap: 0 off/level, 1 on/edge.
// - Link strap: 0 one-bit, 1 four-bit width.
// - Write-protect strap: 0 write once, 1 always.
// - Pull resistors follow reset state.
// - Reset pulls per pin, then pullup or drive.
// - ID-zero-only pulls need processor ID zero.
//
// Chosen here: the placing of the registers and register access over APB.
`include "strap_sampler_regs.svh"
`default_nettype none
module reset_strap_sampler #(
    parameter int CFG_W = 32
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic rstInN,
    input wire logic [`PROC_ID_W-1:0] procId,
    input wire strap_sampler_pkg::pin_vec_t padIn,
    output logic [6:0] padOut,
    output logic [6:0] padOe,
    output logic [6:0] pullUpEn,
    output logic [6:0] pullDnEn,
    input wire strap_sampler_pkg::pin_vec_t funcOut,
    input wire strap_sampler_pkg::pin_vec_t funcOe,
    output logic bootSourceExternal,
    output logic bootRomStart,
    output logic extIrqEnable,
    output logic extIrqEdgeSense,
    output logic linkRxWidth4,
    output logic sysregWriteUnlock,
    output logic [2:0] testModeStraps,
    output logic strapsValid,
    output logic pinsHandedBack,
    output logic [CFG_W-1:0] systemConfig,
    output logic [CFG_W-1:0] sdramConfig,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    import strap_sampler_pkg::*;

    localparam int SYNC_W = `STRAP_PINS + 1 + `PROC_ID_W;
    localparam logic [3:0] HANDBACK_LAST = 4'(`HANDBACK_CYC - 1);

    generate
        if (CFG_W < 1 || CFG_W > 32)
        begin : g_bad_width
            $error("CFG_W must lie between 1 and 32");
        end
        if (`HANDBACK_CYC > 16)
        begin : g_bad_delay
            $error("Hand-back delay exceeds the counter");
        end
        if (`STRAP_PINS != $bits(pin_vec_t))
        begin : g_bad_pins
            $error("Pin count and pin vector width differ");
        end
    endgenerate

    function automatic logic [31:0] widen(input logic [CFG_W-1:0] v);
        logic [31:0] r;
        r = '0;
        r[CFG_W-1:0] = v;
        return r;
    endfunction

    // Pins and the reset pin share one synchroniser, so all arrive with equal latency.
    logic [SYNC_W-1:0] syncQ;
    strap_sync #(
        .W(SYNC_W)
    ) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .d({procId, rstInN, padIn}),
        .q(syncQ)
    );

    wire pin_vec_t padQ = syncQ[`STRAP_PINS-1:0];
    wire logic rstQ = syncQ[`STRAP_PINS];
    wire logic idZero = (syncQ[SYNC_W-1:`STRAP_PINS+1] == '0);

    strap_state_t state_r;
    strap_state_t state_nxt;
    logic rstPrev_r;
    logic [3:0] holdCnt_r;
    pin_vec_t capt_r;

    wire logic releaseEdge = rstQ & ~rstPrev_r;
    wire logic holdDone = (state_r == ST_HANDBACK) && (holdCnt_r == HANDBACK_LAST);

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IN_RESET:
            begin
                if (releaseEdge)
                begin
                    state_nxt = ST_HANDBACK;
                end
            end
            ST_HANDBACK:
            begin
                if (!rstQ)
                begin
                    state_nxt = ST_IN_RESET;
                end
                else if (holdDone)
                begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN:
            begin
                if (!rstQ)
                begin
                    state_nxt = ST_IN_RESET;
                end
            end
            default:
            begin
                state_nxt = ST_IN_RESET;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_r <= ST_IN_RESET;
            rstPrev_r <= 1'b0;
            holdCnt_r <= 4'h0;
        end
        else
        begin
            state_r <= state_nxt;
            rstPrev_r <= rstQ;
            holdCnt_r <= (state_r == ST_HANDBACK) ? holdCnt_r + 4'h1 : 4'h0;
        end
    end

    // The pad level at release already includes the internal pull default.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            capt_r <= '0;
        end
        else if (releaseEdge)
        begin
            capt_r <= padQ;
        end
    end

    // Pad control: pulls during reset and hand-back, then run-time pulls or drive.
    wire logic inRun = (state_nxt == ST_RUN);
    wire pin_vec_t idMask = idZero ? 7'h7f : ~pin_vec_t'(`ID_ZERO_ONLY_MASK);
    wire pin_vec_t upNxt = (inRun ? `RUN_PULL_UP_MASK : `RST_PULL_UP_MASK) & idMask;
    wire pin_vec_t dnNxt = (inRun ? 7'h00 : `RST_PULL_DN_MASK) & idMask;
    wire pin_vec_t oeNxt = inRun ? (pin_vec_t'(`RUN_DRIVEN_MASK) | funcOe) : 7'h00;
    wire pin_vec_t outNxt = inRun ? funcOut : 7'h00;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            padOut <= '0;
            padOe <= '0;
            pullUpEn <= '0;
            pullDnEn <= '0;
        end
        else
        begin
            padOut <= outNxt;
            padOe <= oeNxt;
            pullUpEn <= upNxt;
            pullDnEn <= dnNxt;
        end
    end

    // Mode outputs.
    // The hand-back flag follows the next state, so it moves on the same edge as the pads.
    // The boot pulse is held back if the reset pin returns in the last hand-back cycle.
    wire logic bootStrap = capt_r[`PIN_BOOT_ROM_SELECT];
    wire logic bootGo = holdDone & rstQ;
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            bootSourceExternal <= 1'b0;
            bootRomStart <= 1'b0;
            extIrqEnable <= 1'b0;
            extIrqEdgeSense <= 1'b0;
            linkRxWidth4 <= 1'b0;
            sysregWriteUnlock <= 1'b0;
            testModeStraps <= 3'h7;
            strapsValid <= 1'b0;
            pinsHandedBack <= 1'b0;
        end
        else
        begin
            bootSourceExternal <= bootStrap;
            bootRomStart <= bootGo & ~bootStrap;
            extIrqEnable <= capt_r[`PIN_MASTER_INDICATOR];
            extIrqEdgeSense <= capt_r[`PIN_MASTER_INDICATOR];
            linkRxWidth4 <= capt_r[`PIN_TIMER_ZERO_EXPIRY];
            sysregWriteUnlock <= capt_r[`PIN_ARBITRATION_HOLD];
            // Any low bit here means the board disturbed a test-mode strap.
            testModeStraps <= capt_r[`PIN_LINK_THREE_DONE:`PIN_LINK_ONE_DONE];
            strapsValid <= (state_r != ST_IN_RESET);
            pinsHandedBack <= inRun;
        end
    end

    // APB slave: one wait state, then pready with data; writes commit at the completion edge.
    logic sysWritten_r;
    logic sdrWritten_r;
    wire logic apbAccess = psel & penable & ~pready;
    wire logic apbDone = psel & penable & pready;
    wire logic hitStatus = (paddr == `OFS_STATUS);
    wire logic hitSys = (paddr == `OFS_SYSTEM_CONFIG);
    wire logic hitSdr = (paddr == `OFS_SDRAM_CONFIG);
    wire logic hitAny = hitStatus | hitSys | hitSdr;
    wire logic sysLocked = sysWritten_r & ~sysregWriteUnlock;
    wire logic sdrLocked = sdrWritten_r & ~sysregWriteUnlock;
    wire logic wrRefused = pwrite & ((hitSys & sysLocked) | (hitSdr & sdrLocked));
    wire logic sysWrite = apbDone & pwrite & hitSys & ~sysLocked;
    wire logic sdrWrite = apbDone & pwrite & hitSdr & ~sdrLocked;
    wire logic devReset = sys_rst | ~rstQ;

    logic [31:0] statusWord;
    always_comb
    begin
        statusWord = '0;
        statusWord[`STS_BOOT_BIT] = bootSourceExternal;
        statusWord[`STS_IRQ_BIT] = extIrqEnable;
        statusWord[`STS_LINK_BIT] = linkRxWidth4;
        statusWord[`STS_UNLOCK_BIT] = sysregWriteUnlock;
        statusWord[`STS_TEST_LSB+2:`STS_TEST_LSB] = testModeStraps;
        statusWord[`STS_VALID_BIT] = strapsValid;
        statusWord[`STS_RUN_BIT] = pinsHandedBack;
        statusWord[`STS_SYS_WRITTEN_BIT] = sysWritten_r;
        statusWord[`STS_SDR_WRITTEN_BIT] = sdrWritten_r;
        statusWord[`STS_ID_ZERO_BIT] = idZero;
    end

    wire logic [31:0] readMux = hitStatus ? statusWord :
                                hitSys ? widen(systemConfig) :
                                hitSdr ? widen(sdramConfig) : 32'h0000_0000;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end
        else
        begin
            pready <= apbAccess;
            pslverr <= apbAccess & (~hitAny | wrRefused);
            prdata <= (apbAccess & ~pwrite) ? readMux : 32'h0000_0000;
        end
    end

    // A device reset through the reset pin also reopens the one-time write.
    always_ff @(posedge clk)
    begin
        if (devReset)
        begin
            systemConfig <= CFG_W'(`SYSTEM_CONFIG_RESET);
            sdramConfig <= CFG_W'(`SDRAM_CONFIG_RESET);
            sysWritten_r <= 1'b0;
            sdrWritten_r <= 1'b0;
        end
        else
        begin
            if (sysWrite)
            begin
                systemConfig <= pwdata[CFG_W-1:0];
                sysWritten_r <= 1'b1;
            end
            if (sdrWrite)
            begin
                sdramConfig <= pwdata[CFG_W-1:0];
                sdrWritten_r <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// *** strap_board.sv ***
// Board strapping model that sets the level of each dual-use pad.
`default_nettype none
module strap_board (
    input wire logic clk,
    input wire logic [6:0] strapVal,
    input wire logic [6:0] strapDrv,
    input wire logic [6:0] padOut,
    input wire logic [6:0] padOe,
    input wire logic [6:0] pullUpEn,
    input wire logic [6:0] pullDnEn,
    output logic [6:0] padIn
);
    logic [6:0] floatLvl = 7'h55;
    // The board never overdrives the test-mode straps.
    wire logic [6:0] boardDrv = strapDrv & 7'h0f;
    // A floating pad toggles so that no capture can rely on a settled unknown.
    always_ff @(posedge clk)
        floatLvl <= ~floatLvl;
    always_comb
        for (int i = 0; i < 7; i++)
            padIn[i] = padOe[i] ? padOut[i] : boardDrv[i] ? strapVal[i] :
                pullUpEn[i] ? 1'b1 : pullDnEn[i] ? 1'b0 : floatLvl[i];
endmodule
`default_nettype wire

// *** reset_strap_sampler_props.sv ***
// Port-level assertions for the reset strap sampler.
`include "strap_sampler_regs.svh"
`default_nettype none
module strap_sampler_checker (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic rstInN,
    input wire logic [`PROC_ID_W-1:0] procId,
    input wire logic [6:0] padOe,
    input wire logic [6:0] pullUpEn,
    input wire logic [6:0] pullDnEn,
    input wire logic bootSourceExternal,
    input wire logic bootRomStart,
    input wire logic extIrqEnable,
    input wire logic extIrqEdgeSense,
    input wire logic linkRxWidth4,
    input wire logic sysregWriteUnlock,
    input wire logic [2:0] testModeStraps,
    input wire logic strapsValid,
    input wire logic pinsHandedBack,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    sequence capSeq;
        ##[1:4] strapsValid;
    endsequence
    sequence backSeq;
        ##[1:8] pinsHandedBack;
    endsequence
    capture_done_a: assert property ($rose(rstInN) |-> capSeq)
        else $error("straps not captured");
    pins_returned_a: assert property ($rose(strapsValid) |-> backSeq)
        else $error("pins not handed back");
    irq_pair_a: assert property (extIrqEnable == extIrqEdgeSense)
        else $error("interrupt enable and edge differ");
    test_straps_a: assert property (strapsValid |-> testModeStraps == 3'h7)
        else $error("test mode strap captured low");
    modes_hold_a: assert property (strapsValid && $past(strapsValid) |->
        $stable({bootSourceExternal, extIrqEnable, linkRxWidth4, sysregWriteUnlock,
        testModeStraps}))
        else $error("modes changed");
    // The raw id is compared undelayed here, though the design sees it through a synchroniser.
    reset_pulls_a: assert property (!$past(rstInN, 4) && !$past(rstInN, 5) &&
        !$past(sys_rst, 5) |-> padOe == 7'h00 && pullUpEn == 7'h70 &&
        pullDnEn == (procId == 3'h0 ? 7'h0f : 7'h06))
        else $error("reset pulls wrong");
    run_pads_a: assert property (pinsHandedBack |-> (padOe & 7'h76) == 7'h76 &&
        pullDnEn == 7'h00 && pullUpEn == ($past(procId, 4) == 3'h0 ? 7'h09 : 7'h00))
        else $error("run pads wrong");
    boot_start_a: assert property ($rose(pinsHandedBack) |->
        bootRomStart == !bootSourceExternal ##1 !bootRomStart)
        else $error("boot start wrong");
    apb_answer_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
        else $error("bus answer late");
endmodule
bind reset_strap_sampler strap_sampler_checker strap_sampler_checker_inst (
    .clk(clk), .sys_rst(sys_rst), .rstInN(rstInN), .procId(procId), .padOe(padOe),
    .pullUpEn(pullUpEn), .pullDnEn(pullDnEn), .bootSourceExternal(bootSourceExternal),
    .bootRomStart(bootRomStart), .extIrqEnable(extIrqEnable),
    .extIrqEdgeSense(extIrqEdgeSense), .linkRxWidth4(linkRxWidth4),
    .sysregWriteUnlock(sysregWriteUnlock), .testModeStraps(testModeStraps),
    .strapsValid(strapsValid), .pinsHandedBack(pinsHandedBack), .psel(psel),
    .penable(penable), .pready(pready)
);
`default_nettype wire

// *** reset_strap_sampler_bench.sv ***
// Self-checking bench for the reset strap sampler.
`default_nettype none
module reset_strap_sampler_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, sys_rst = 1, rstInN = 0, psel = 0, penable = 0, pwrite = 0;
    logic seenPulse, e, bootSourceExternal, bootRomStart, extIrqEnable, extIrqEdgeSense;
    logic linkRxWidth4, sysregWriteUnlock, strapsValid, pinsHandedBack, pready, pslverr;
    logic [2:0] procId = 3'h0, testModeStraps;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, q, prdata;
    logic [6:0] strapVal = 7'h00, strapDrv = 7'h00, funcOut = 7'h00, funcOe = 7'h00;
    logic [6:0] padIn, padOut, padOe, pullUpEn, pullDnEn;
    int err_count = 0, check_count = 0;
    wire logic [7:0] modes = {bootSourceExternal, extIrqEnable, extIrqEdgeSense,
        linkRxWidth4, sysregWriteUnlock, testModeStraps};
    reset_strap_sampler reset_strap_sampler_inst (.*, .systemConfig(), .sdramConfig());
    strap_board strap_board_inst (.*);
    initial
        forever #25 clk = ~clk;
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
            err_count++;
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20)
        begin
            err_count++;
            give_verdict();
        end
    endtask
    task automatic strap(input logic [6:0] v, input logic [6:0] drv, input logic [2:0] id);
        int n;
        @(posedge clk);
        rstInN <= 1'b0;
        strapVal <= v;
        strapDrv <= drv;
        procId <= id;
        repeat (8) @(posedge clk);
        chk("rst pu", 32'(pullUpEn), 32'h70);
        chk("rst pd", 32'(pullDnEn), (id == 3'h0) ? 32'h0f : 32'h06);
        chk("rst oe", 32'(padOe), 32'h00);
        rstInN <= 1'b1;
        seenPulse = 1'b0;
        n = 0;
        while (pinsHandedBack !== 1'b1 && n < 30)
        begin
            @(posedge clk);
            seenPulse |= bootRomStart;
            n++;
        end
        if (n >= 30)
        begin
            err_count++;
            give_verdict();
        end
        // Flipping the strap values after capture reaches only pad 0, where the board drives it; the modes must ignore it.
        strapVal <= ~v;
        funcOe <= 7'h08;
        funcOut <= 7'h2a;
        repeat (3) @(posedge clk);
        chk("run oe", 32'(padOe), 32'h7e);
        chk("run out", 32'(padOut), 32'h2a);
        chk("run pu", 32'(pullUpEn), (id == 3'h0) ? 32'h09 : 32'h00);
    endtask
    initial
    begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        strap(7'h00, 7'h00, 3'h0);
        chk("modes", 32'(modes), 32'h07);
        chk("rom boot", 32'(seenPulse), 32'h1);
        apb(1'b1, 12'h004, 32'h1234_5678);
        chk("wr1 err", 32'(e), 32'h0);
        apb(1'b1, 12'h004, 32'hcafe_0001);
        chk("wr2 err", 32'(e), 32'h1);
        apb(1'b0, 12'h004, 32'h0);
        chk("locked", q, 32'h1234_5678);
        apb(1'b0, 12'hffc, 32'h0);
        chk("unmapped", 32'(e), 32'h1);
        $display("test defaults done");
        strap(7'h0f, 7'h0f, 3'h0);
        chk("modes", 32'(modes), 32'hff);
        chk("no rom boot", 32'(seenPulse), 32'h0);
        apb(1'b1, 12'h008, 32'h0000_00a5);
        apb(1'b1, 12'h008, 32'h0000_005a);
        chk("wr2 err", 32'(e), 32'h0);
        apb(1'b0, 12'h008, 32'h0);
        chk("unlocked", q, 32'h0000_005a);
        apb(1'b1, 12'h000, 32'hffff_ffff);
        chk("status wr err", 32'(e), 32'h0);
        apb(1'b0, 12'h000, 32'h0);
        chk("status", q, 32'h0000_1b7f);
        $display("test strapped done");
        strap(7'h05, 7'h0f, 3'h5);
        chk("modes mixed", 32'(modes), 32'h97);
        chk("no rom boot id", 32'(seenPulse), 32'h0);
        $display("test nonzero id done");
        give_verdict();
    end
endmodule
`default_nettype wire
